/* File: rtl/spl_pkg.sv */
// Package: register map, field positions, reset values and states of the serial port block
package spl_pkg;
  // ==========================================================
  // Register indices (byte offsets on the plain register port)
  localparam logic [2:0] SPL_ADDR_CTRL1 = 3'h0;
  localparam logic [2:0] SPL_ADDR_CTRL2 = 3'h1;
  localparam logic [2:0] SPL_ADDR_STAT1 = 3'h2;
  localparam logic [2:0] SPL_ADDR_STAT2 = 3'h3;
  localparam logic [2:0] SPL_ADDR_DATAH = 3'h4;
  localparam logic [2:0] SPL_ADDR_DATAL = 3'h5;
  localparam logic [2:0] SPL_ADDR_BAUD = 3'h6;
  // ==========================================================
  // control_register_1 fields
  localparam int SPL_C1_LOOP = 7;
  localparam int SPL_C1_WAITH = 6;
  localparam int SPL_C1_RECEIVER_SOURCE_SELECT = 5;
  localparam int SPL_C1_NINE = 4;
  // control_register_2 fields
  localparam int SPL_C2_TIE = 7;
  localparam int SPL_C2_TX_COMPLETE_IRQ_ENABLE = 6;
  localparam int SPL_C2_RIE = 5;
  localparam int SPL_C2_LINE_QUIET_IRQ_ENABLE = 4;
  localparam int SPL_C2_TE = 3;
  localparam int SPL_C2_RE = 2;
  // status_register_1 fields
  localparam int SPL_S1_TDE = 7;
  localparam int SPL_S1_TCF = 6;
  localparam int SPL_S1_RDF = 5;
  localparam int SPL_S1_IDL = 4;
  localparam int SPL_S1_OVR = 3;
  // status_register_2 field
  localparam int SPL_S2_DIR = 1;
  // ==========================================================
  // Reset values and timing
  localparam logic [7:0] SPL_BAUD_RST = 8'h04;
  localparam logic [3:0] SPL_OVS_LAST = 4'hF;
  localparam logic [3:0] SPL_OVS_MID = 4'h7;
  localparam logic [3:0] SPL_IDLE_8 = 4'hA;
  localparam logic [3:0] SPL_IDLE_9 = 4'hB;
  localparam logic [3:0] SPL_BITS_8 = 4'h9;
  localparam logic [3:0] SPL_BITS_9 = 4'hA;
  typedef enum logic [1:0] {
    SPL_TX_IDLE = 2'b00,
    SPL_TX_SHIFT = 2'b01
  } spl_tx_t;
endpackage

/* File: rtl/spl_rate.sv */
// Baud divider producing a one-cycle tick at sixteen times the bit rate
`timescale 1ns/100ps
module spl_rate
  import spl_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic [W-1:0] div,
  output logic tick
);
  logic [W-1:0] cnt_r;
  // ==========================================================
  // Counter freezes while run is low, so frames resume in place
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else if (!run) begin
      tick <= 1'b0;
    end else if (cnt_r >= div) begin
      cnt_r <= '0;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule

/* File: rtl/spl_top.sv */
// Serial port: loop-back and single-wire routing, low-power freeze, five-source interrupt
//
// Overview of operation
// - Loop select high cuts the external receive pin off the receiver.
// - Loop plus source select feeds receiver from the transmit pin (its driver when direction bit is 1).
// - Loop with source select low routes transmitter output into receiver.
// - Single-wire: direction bit 0 makes the pin an input, 1 drives it.
// - Wait-halt clear: block keeps running in CPU wait.
// - Wait-halt set: clocks stop in wait, enable bits unchanged.
// - With wait-halt set, frames freeze at wait entry and resume on wakeup.
// - Reset during wait abandons transfers and restores reset state.
// - Stop mode freezes everything, keeps registers, resumes afterwards.
// - Reset during stop aborts transfers and resets the block.
// - Five enabled sources are ORed onto one active-high request.
// - Transmit-empty sets when the shifter takes a character.
// - Transmit-empty clears on status read then low data write.
// - Transmit-complete sets when empty and idle; pin idles high.
// - Complete clears on status read plus data write, or when data queued.
// - Receive-full sets on transfer; clears on status read then data read.
// - Overrun sets on a new frame before read; new frame dropped.
// - Overrun clears on status read then low data read.
// - Idle sets after 10 ones (8-bit) or 11 ones (9-bit).
// - After idle clears, it rearms only once receive-full has set.
// - Idle clears on status read then low data read.
`timescale 1ns/100ps
module spl_top
  import spl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic cpu_wait,
  input wire logic cpu_stop,
  input wire logic rx_pin,
  input wire logic tx_pin_in,
  output logic tx_pin_out,
  output logic tx_pin_oe,
  output logic irq
);
  // ==========================================================
  // Registers
  logic [7:0] ctrl1_r;
  logic [7:0] ctrl2_r;
  logic [7:0] baud_r;
  logic dir_r;
  logic [8:0] tdata_r;
  logic [8:0] rdata_r;
  logic tde_r, tcf_r, rdf_r, idl_r, ovr_r;
  logic armed_tx_r, armed_rx_r, idle_arm_r;
  logic tx_pend_r;
  logic tick;
  logic run;
  logic loop_sel, nine;
  logic tx_bit;
  logic rx_in;
  logic tx_load, rx_done;
  logic wr_dl, rd_dl, rd_s1;

  assign loop_sel = ctrl1_r[SPL_C1_LOOP];
  assign nine = ctrl1_r[SPL_C1_NINE];
  assign wr_dl = reg_wr && (reg_addr == SPL_ADDR_DATAL);
  assign rd_dl = reg_rd && (reg_addr == SPL_ADDR_DATAL);
  assign rd_s1 = reg_rd && (reg_addr == SPL_ADDR_STAT1);

  // Stop always freezes; wait freezes only with wait-halt set
  assign run = !cpu_stop && !(cpu_wait && ctrl1_r[SPL_C1_WAITH]);

  // ==========================================================
  // Receive routing
  always_comb begin
    if (!loop_sel) begin
      rx_in = rx_pin;
    end else if (ctrl1_r[SPL_C1_RECEIVER_SOURCE_SELECT]) begin
      rx_in = dir_r ? tx_pin_out : tx_pin_in;
    end else begin
      rx_in = tx_bit;
    end
  end

  spl_rate #(.W(8)) u_rate (
    .clk(clk),
    .rst_b(rst_b),
    .run(run),
    .div(baud_r),
    .tick(tick)
  );

  // ==========================================================
  // Register writes; enables untouched by low-power modes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl1_r <= 8'h00;
      ctrl2_r <= 8'h00;
      baud_r <= SPL_BAUD_RST;
      dir_r <= 1'b0;
      tdata_r <= 9'h000;
    end else if (reg_wr) begin
      if (reg_addr == SPL_ADDR_CTRL1) begin
        ctrl1_r <= reg_wdata;
      end else if (reg_addr == SPL_ADDR_CTRL2) begin
        ctrl2_r <= reg_wdata;
      end else if (reg_addr == SPL_ADDR_STAT2) begin
        dir_r <= reg_wdata[SPL_S2_DIR];
      end else if (reg_addr == SPL_ADDR_DATAH) begin
        tdata_r[8] <= reg_wdata[0];
      end else if (reg_addr == SPL_ADDR_DATAL) begin
        tdata_r[7:0] <= reg_wdata;
      end else if (reg_addr == SPL_ADDR_BAUD) begin
        baud_r <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // Transmitter
  spl_tx_t tx_st_r;
  logic [3:0] tx_ovs_r;
  logic [3:0] tx_cnt_r;
  logic [10:0] tx_sh_r;
  assign tx_bit = (tx_st_r == SPL_TX_SHIFT) ? tx_sh_r[0] : 1'b1;
  assign tx_load = run && tick && (tx_st_r == SPL_TX_IDLE) && tx_pend_r
                   && ctrl2_r[SPL_C2_TE];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_st_r <= SPL_TX_IDLE;
      tx_ovs_r <= 4'h0;
      tx_cnt_r <= 4'h0;
      tx_sh_r <= 11'h7FF;
    end else if (tx_load) begin
      tx_st_r <= SPL_TX_SHIFT;
      tx_ovs_r <= 4'h0;
      tx_cnt_r <= 4'h0;
      // Eight-bit frames put the stop bit where the ninth data bit would go
      tx_sh_r <= {1'b1, tdata_r[8] | !nine, tdata_r[7:0], 1'b0};
    end else if (run && tick && tx_st_r == SPL_TX_SHIFT) begin
      tx_ovs_r <= tx_ovs_r + 1'b1;
      if (tx_ovs_r == SPL_OVS_LAST) begin
        tx_sh_r <= {1'b1, tx_sh_r[10:1]};
        tx_cnt_r <= tx_cnt_r + 1'b1;
        if (tx_cnt_r == (nine ? SPL_BITS_9 : SPL_BITS_8)) begin
          tx_st_r <= SPL_TX_IDLE;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_pin_out <= 1'b1;
      tx_pin_oe <= 1'b1;
    end else begin
      tx_pin_out <= tx_bit;
      tx_pin_oe <= !(loop_sel && ctrl1_r[SPL_C1_RECEIVER_SOURCE_SELECT]) || dir_r;
    end
  end

  // ==========================================================
  // Receiver: centre sampling, no noise filter here
  logic rx_busy_r;
  logic [3:0] rx_ovs_r, rx_cnt_r, ones_r;
  logic [9:0] rx_sh_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_busy_r <= 1'b0;
      rx_ovs_r <= 4'h0;
      rx_cnt_r <= 4'h0;
      rx_sh_r <= 10'h000;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (run && tick && ctrl2_r[SPL_C2_RE]) begin
        if (!rx_busy_r) begin
          if (!rx_in) begin
            rx_busy_r <= 1'b1;
            rx_ovs_r <= 4'h0;
            rx_cnt_r <= 4'h0;
          end
        end else begin
          rx_ovs_r <= rx_ovs_r + 1'b1;
          if (rx_ovs_r == SPL_OVS_MID) begin
            rx_sh_r <= {rx_in, rx_sh_r[9:1]};
            rx_cnt_r <= rx_cnt_r + 1'b1;
            if (rx_cnt_r == (nine ? SPL_BITS_9 : SPL_BITS_8)) begin
              rx_busy_r <= 1'b0;
              rx_done <= 1'b1;
            end
          end
        end
      end
    end
  end

  // Idle count of ones, one per bit time
  logic [3:0] bt_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ones_r <= 4'h0;
      bt_r <= 4'h0;
    end else if (run && tick) begin
      bt_r <= bt_r + 1'b1;
      if (!rx_in) begin
        ones_r <= 4'h0;
        bt_r <= 4'h0;
      end else if (bt_r == SPL_OVS_LAST && ones_r != SPL_IDLE_9) begin
        ones_r <= ones_r + 1'b1;
      end
    end
  end

  // ==========================================================
  // Flags; a hardware set wins over a software clear
  logic idle_hit;
  assign idle_hit = (ones_r >= (nine ? SPL_IDLE_9 : SPL_IDLE_8));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_tx_r <= 1'b0;
      armed_rx_r <= 1'b0;
    end else begin
      if (rd_s1) begin
        armed_tx_r <= tde_r || tcf_r;
        armed_rx_r <= rdf_r || ovr_r || idl_r;
      end else if (wr_dl) begin
        armed_tx_r <= 1'b0;
      end else if (rd_dl) begin
        armed_rx_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tde_r <= 1'b1;
      tx_pend_r <= 1'b0;
      tcf_r <= 1'b1;
    end else begin
      if (tx_load) begin
        tde_r <= 1'b1;
        tx_pend_r <= 1'b0;
      end else if (wr_dl && armed_tx_r) begin
        tde_r <= 1'b0;
        tx_pend_r <= 1'b1;
      end
      if (tde_r && !tx_pend_r && tx_st_r == SPL_TX_IDLE) begin
        tcf_r <= 1'b1;
      end else if ((wr_dl && armed_tx_r) || tx_pend_r) begin
        tcf_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdf_r <= 1'b0;
      ovr_r <= 1'b0;
      idl_r <= 1'b0;
      idle_arm_r <= 1'b0;
      rdata_r <= 9'h000;
    end else begin
      if (rx_done && !rdf_r) begin
        rdf_r <= 1'b1;
        idle_arm_r <= 1'b1;
        if (nine) begin
          rdata_r <= rx_sh_r[8:0];
        end else begin
          rdata_r <= {1'b0, rx_sh_r[8:1]};
        end
      end else if (rd_dl && armed_rx_r) begin
        rdf_r <= 1'b0;
      end
      if (rx_done && rdf_r) begin
        ovr_r <= 1'b1;
      end else if (rd_dl && armed_rx_r) begin
        ovr_r <= 1'b0;
      end
      if (idle_hit && idle_arm_r) begin
        idl_r <= 1'b1;
        idle_arm_r <= 1'b0;
      end else if (rd_dl && armed_rx_r) begin
        idl_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read port and interrupt
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == SPL_ADDR_CTRL1) begin
        reg_rdata <= ctrl1_r;
      end else if (reg_addr == SPL_ADDR_CTRL2) begin
        reg_rdata <= ctrl2_r;
      end else if (reg_addr == SPL_ADDR_STAT1) begin
        reg_rdata <= {tde_r, tcf_r, rdf_r, idl_r, ovr_r, 3'h0};
      end else if (reg_addr == SPL_ADDR_STAT2) begin
        reg_rdata <= {6'h00, dir_r, rx_busy_r};
      end else if (reg_addr == SPL_ADDR_DATAH) begin
        reg_rdata <= {7'h00, rdata_r[8]};
      end else if (reg_addr == SPL_ADDR_DATAL) begin
        reg_rdata <= rdata_r[7:0];
      end else if (reg_addr == SPL_ADDR_BAUD) begin
        reg_rdata <= baud_r;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= (tde_r && ctrl2_r[SPL_C2_TIE]) || (tcf_r && ctrl2_r[SPL_C2_TX_COMPLETE_IRQ_ENABLE])
             || ((rdf_r || ovr_r) && ctrl2_r[SPL_C2_RIE])
             || (idl_r && ctrl2_r[SPL_C2_LINE_QUIET_IRQ_ENABLE]);
    end
  end

  // ==========================================================
  // Assertions
  property p_loop_cut;
    @(posedge clk) disable iff (!rst_b) loop_sel && !ctrl1_r[SPL_C1_RECEIVER_SOURCE_SELECT] |-> rx_in == tx_bit;
  endproperty
  a_loop_cut: assert property (p_loop_cut) else $error("loop routing wrong");
  property p_freeze;
    @(posedge clk) disable iff (!rst_b) cpu_stop |=> $stable(tx_st_r) && $stable(tx_sh_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("frame moved in stop");
  property p_tde_set;
    @(posedge clk) disable iff (!rst_b) tx_load |=> tde_r;
  endproperty
  a_tde_set: assert property (p_tde_set) else $error("empty not set on load");
  property p_tde_clr;
    @(posedge clk) disable iff (!rst_b) tde_r && !armed_tx_r && !tx_load |=> tde_r;
  endproperty
  a_tde_clr: assert property (p_tde_clr) else $error("empty cleared unarmed");
  property p_ovr;
    @(posedge clk) disable iff (!rst_b) rx_done && rdf_r |=> ovr_r && $stable(rdata_r);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun handling wrong");
  property p_irq;
    @(posedge clk) disable iff (!rst_b) rdf_r && ctrl2_r[SPL_C2_RIE] |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_tx_idle;
    @(posedge clk) disable iff (!rst_b) tcf_r |-> tx_bit;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("pin not idle");
  property p_idle_arm;
    @(posedge clk) disable iff (!rst_b) !idl_r && !idle_arm_r |=> !idl_r;
  endproperty
  a_idle_arm: assert property (p_idle_arm) else $error("idle rose unarmed");
  c_load: cover property (@(posedge clk) tx_load);
  c_done: cover property (@(posedge clk) rx_done);
  c_ovr: cover property (@(posedge clk) rx_done && rdf_r);
endmodule

/* File: testbench/spl_remote.sv */
// Remote serial station: drives the receive line and captures frames from the transmit pin
`timescale 1ns/100ps
module spl_remote #(
  parameter int BT = 16
) (
  input wire logic clk,
  input wire logic tx_line,
  output logic ln
);
  initial ln = 1'b1;
  // ==========================================================
  // Sender, line idles high between frames
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      ln <= f[i];
      repeat (BT) @(posedge clk);
    end
  endtask
  // ==========================================================
  // Catcher samples mid-bit, so a stretched frame would be misread
  task automatic grab(output logic [7:0] d);
    int n;
    n = 0;
    while (tx_line === 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    repeat (BT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BT) @(posedge clk);
      d[i] = tx_line;
    end
    repeat (BT) @(posedge clk);
  endtask
endmodule

/* File: testbench/spl_top_test.sv */
// Self-checking bench for the serial port block
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module spl_top_test;
  import spl_pkg::*;
  localparam logic [2:0] C1 = SPL_ADDR_CTRL1;
  localparam logic [2:0] C2 = SPL_ADDR_CTRL2;
  localparam logic [2:0] S1 = SPL_ADDR_STAT1;
  localparam logic [2:0] DL = SPL_ADDR_DATAL;
  logic clk, rst_b, reg_wr, reg_rd, cpu_wait, cpu_stop;
  logic tx_pin_out, tx_pin_oe, irq, rem_ln, solo;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v, g0, g1;
  int err_total = 0;
  int comparisons = 0;
  logic [7:0] ien [4] = '{8'h80, 8'h40, 8'h30, 8'h00};
  logic iexp [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  // Released transmit pin follows the remote line; the remote drives it in single-wire mode
  wire logic pin_w = tx_pin_oe ? tx_pin_out : rem_ln;
  spl_top dut (
    .clk(clk),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .cpu_wait(cpu_wait),
    .cpu_stop(cpu_stop),
    .rx_pin(rem_ln | solo),
    .tx_pin_in(pin_w),
    .tx_pin_out(tx_pin_out),
    .tx_pin_oe(tx_pin_oe),
    .irq(irq)
  );
  spl_remote #(.BT(16)) rem (
    .clk(clk),
    .tx_line(pin_w),
    .ln(rem_ln)
  );
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ==========================================================
  // Register port tasks, entered just after a rising edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask
  task automatic complete_run();
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic poll(input int b);
    logic [7:0] d;
    for (int n = 0; n < 2000; n++) begin
      rd(S1, d);
      if (d[b] === 1'b1) return;
    end
    err_total++;
    complete_run();
  endtask
  task automatic bits(input int n);
    repeat (n * 16) @(posedge clk);
  endtask
  // Queue one character and run 64 clocks into its frame, four bit times at divisor 0
  task automatic kick(input logic [7:0] d);
    logic [7:0] s;
    rd(S1, s);
    wr(DL, d);
    bits(4);
  endtask
  // Enter wait or stop and check that the transmit line does not move
  task automatic frz(input logic stp);
    logic p;
    int chg;
    chg = 0;
    cpu_wait <= ~stp;
    cpu_stop <= stp;
    repeat (2) @(posedge clk);
    p = tx_pin_out;
    repeat (200) begin
      @(posedge clk);
      if (tx_pin_out !== p) chg++;
    end
    `CHK(chg, 0)
  endtask
  // Reset pulse taken while the CPU sits in wait or stop
  task automatic pulse();
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    cpu_wait <= 1'b0;
    cpu_stop <= 1'b0;
    @(posedge clk);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cpu_wait = 1'b0;
    cpu_stop = 1'b0;
    solo = 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc(S1, 8'hC0);
    rdc(SPL_ADDR_BAUD, SPL_BAUD_RST);
    rdc(3'h7, 8'h00);
    `CHK(tx_pin_out, 1'b1)
    foreach (ien[i]) begin
      wr(C2, ien[i]);
      repeat (2) @(posedge clk);
      `CHK(irq, iexp[i])
    end
    wr(SPL_ADDR_BAUD, 8'h00);
    wr(C2, 8'h0C);
    fork
      begin
        rem.grab(g0);
        rem.grab(g1);
      end
      begin
        wr(DL, 8'hA5);
        repeat (20) @(posedge clk);
        rdc(S1, 8'h80);
        wr(DL, 8'h5A);
        rdc(S1, 8'h00);
      end
    join
    `CHK(g0, 8'hA5)
    `CHK(g1, 8'h5A)
    poll(SPL_S1_TCF);
    `CHK(tx_pin_out, 1'b1)
    wr(C2, 8'h2C);
    rem.send(8'h3C);
    rem.send(8'h99);
    bits(12);
    rdc(S1, 8'hF8);
    `CHK(irq, 1'b1)
    rdc(DL, 8'h3C);
    rdc(S1, 8'hC0);
    `CHK(irq, 1'b0)
    bits(12);
    rdc(S1, 8'hC0);
    wr(C1, 8'h80);
    rem.send(8'h11);
    bits(2);
    rdc(S1, 8'hC0);
    wr(DL, 8'h5A);
    poll(SPL_S1_RDF);
    rdc(DL, 8'h5A);
    wr(C1, 8'hA0);
    wr(SPL_ADDR_STAT2, 8'h00);
    `CHK(tx_pin_oe, 1'b0)
    // Receive pin held high, so the frame can only arrive over the transmit pin
    solo <= 1'b1;
    rem.send(8'h69);
    poll(SPL_S1_RDF);
    solo <= 1'b0;
    rdc(DL, 8'h69);
    wr(SPL_ADDR_STAT2, 8'h02);
    @(posedge clk);
    `CHK(tx_pin_oe, 1'b1)
    wr(C1, 8'h00);
    cpu_wait <= 1'b1;
    rd(S1, v);
    wr(DL, 8'h3A);
    rem.grab(g0);
    `CHK(g0, 8'h3A)
    cpu_wait <= 1'b0;
    wr(C1, 8'h40);
    kick(8'hC3);
    frz(1'b0);
    cpu_wait <= 1'b0;
    poll(SPL_S1_TCF);
    rdc(C2, 8'h2C);
    kick(8'h0F);
    frz(1'b1);
    cpu_stop <= 1'b0;
    poll(SPL_S1_TCF);
    kick(8'hE7);
    frz(1'b0);
    pulse();
    rdc(S1, 8'hC0);
    rdc(C1, 8'h00);
    `CHK(tx_pin_out, 1'b1)
    wr(C2, 8'h0C);
    kick(8'h7E);
    frz(1'b1);
    pulse();
    rdc(S1, 8'hC0);
    rdc(C2, 8'h00);
    `CHK(tx_pin_out, 1'b1)
    complete_run();
  end
endmodule
